// >>> core/param_store_pkg.sv
// Package for the parameter access validator: constant numbers, defaults,
// register offsets, bus and interrupt layouts.
// Assumes one 20 MHz clock shared by every user of the package.
package param_store_pkg;
  // Clock rate and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int ERR_SHOW_MS = 1000; // Error indication time in ms
  localparam int ERR_SHOW_CYCLES = (CLK_HZ / 1000) * ERR_SHOW_MS;
  localparam int TICK_US = 1000; // One tick per millisecond
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICKS_PER_SHOW = ERR_SHOW_MS;

  // Constant numbers
  localparam logic [7:0] NUM_LEVEL = 8'h01;
  localparam logic [7:0] NUM_MODE = 8'h02;
  localparam logic [7:0] NUM_MAX_FREQ = 8'h0B;
  localparam logic [7:0] NUM_MAX_VOLT = 8'h0C;
  localparam logic [7:0] NUM_BASE_FREQ = 8'h0D;
  localparam logic [7:0] NUM_MID_FREQ = 8'h0E;
  localparam logic [7:0] NUM_MID_VOLT = 8'h0F;
  localparam logic [7:0] NUM_MIN_FREQ = 8'h10;
  localparam logic [7:0] NUM_MIN_VOLT = 8'h11;
  localparam logic [7:0] NUM_TIME_UNIT = 8'h12;
  localparam logic [7:0] NUM_RAMP_FIRST = 8'h13;
  localparam logic [7:0] NUM_RAMP_LAST = 8'h16;
  localparam logic [7:0] NUM_UPPER = 8'h21;
  localparam logic [7:0] NUM_LOWER = 8'h22;
  localparam logic [7:0] NUM_CURRENT = 8'h24;
  localparam logic [7:0] NUM_IN_FIRST = 8'h32;
  localparam logic [7:0] NUM_IN_LAST = 8'h38;
  localparam logic [7:0] NUM_SKIP_ONE = 8'h53;
  localparam logic [7:0] NUM_SKIP_TWO = 8'h54;
  localparam logic [7:0] NUM_SKIP_THREE = 8'h55;
  localparam logic [7:0] NUM_SECOND_A = 8'h8C;
  localparam logic [7:0] NUM_SECOND_B = 8'h93;
  localparam logic [7:0] NUM_TOP = 8'hB3;

  // Write ceilings per access level
  localparam logic [7:0] LIMIT_L1 = 8'h31;
  localparam logic [7:0] LIMIT_L2 = 8'h4F;
  localparam logic [7:0] LIMIT_L3 = 8'h77;
  localparam logic [7:0] LIMIT_L4 = 8'hB3;

  // Special level values
  localparam logic [15:0] LEVEL_RUN_PROG = 16'h0005;
  localparam logic [15:0] LEVEL_CLR_FAULT = 16'h0006;
  localparam logic [15:0] LEVEL_INIT = 16'h000C;
  localparam logic [15:0] LEVEL_INIT_3W = 16'h000D;

  // Defaults, 0.1 Hz / 0.1 V units
  localparam logic [15:0] DEF_LEVEL = 16'h0001;
  localparam logic [15:0] DEF_MAX_FREQ = 16'h01F4;
  localparam logic [15:0] DEF_MAX_VOLT = 16'h07D0;
  localparam logic [15:0] DEF_BASE_FREQ = 16'h01F4;
  localparam logic [15:0] DEF_MID_FREQ = 16'h000D;
  localparam logic [15:0] DEF_MID_VOLT = 16'h0078;
  localparam logic [15:0] DEF_MIN_FREQ = 16'h000D;
  localparam logic [15:0] DEF_MIN_VOLT = 16'h0078;
  localparam logic [15:0] DEF_SECOND_LIM = 16'h01F4;
  localparam logic [15:0] DEF_RAMP = 16'h0064;
  localparam logic [15:0] DEF_UPPER = 16'h03E8;
  localparam logic [15:0] DEF_CURRENT = 16'h0000;
  localparam logic [15:0] BASE_MIN = 16'h0002;
  localparam logic [15:0] BASE_MAX = 16'h0FA0;
  localparam logic [15:0] RAMP_LIMIT = 16'h1770; // 600.0 s in 0.1 s
  localparam logic [15:0] UNIT_FINE = 16'h0001;
  localparam logic [15:0] MODE_VECTOR = 16'h0001;

  // AXI register byte offsets
  localparam logic [11:0] OFS_DATA_BASE = 12'h000; // Word n at 4*n
  localparam logic [11:0] OFS_STATUS = 12'h400;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h404;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h408;
  localparam logic [11:0] OFS_DRIVE_RATED = 12'h40C;
  localparam int IRQ_BITS = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Event layout of status and mask
  typedef struct packed {
    logic init_done;
    logic fault_clr;
    logic set_error;
  } irq_t;

  // One store access
  typedef struct packed {
    logic [7:0] num;
    logic [15:0] data;
  } access_t;
endpackage : param_store_pkg

// >>> core/err_timer.sv
// One-second error indication timer on a millisecond tick.
// Assumes the start pulse is one cycle and synchronous to aclk.
`timescale 1ns/1ps
module err_timer #(
  parameter int TICK_LEN = param_store_pkg::TICK_CYCLES,
  parameter int TICKS = param_store_pkg::TICKS_PER_SHOW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic showing
);
  import param_store_pkg::*;
  initial begin
    if (TICK_LEN < 1 || TICKS < 1) $error("err_timer counts must be positive");
  end
  logic [31:0] tick_cnt_r; // Cycles within a tick
  logic [31:0] ms_cnt_r; // Ticks left to show

  // Tick divider, restarted by a new error
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == 32'(TICK_LEN - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // Remaining ticks; restart wins over expiry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_r <= '0;
    end else if (start) begin
      ms_cnt_r <= 32'(TICKS);
    end else if (ms_cnt_r != 32'h0 && tick_cnt_r == 32'(TICK_LEN - 1)) begin
      ms_cnt_r <= ms_cnt_r - 32'h1;
    end
  end

  // Indication stays up while ticks remain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      showing <= 1'b0;
    end else begin
      showing <= start || (ms_cnt_r > 32'h1) ||
                 (ms_cnt_r == 32'h1 && tick_cnt_r != 32'(TICK_LEN - 1));
    end
  end
endmodule : err_timer

// >>> core/level_decode.sv
// Access level decode: write ceiling, readability and run permission.
// Assumes the level value is the stored access level constant.
`timescale 1ns/1ps
module level_decode (
  input wire logic [15:0] level,
  input wire logic [7:0] num,
  output logic write_ok,
  output logic assigned,
  output logic run_in_prog
);
  import param_store_pkg::*;
  logic [7:0] ceiling; // Highest writable number

  // Ceiling per level; unknown levels lock all but the level itself
  always_comb begin
    unique case (level)
      16'h0001: ceiling = LIMIT_L1;
      16'h0002: ceiling = LIMIT_L2;
      16'h0003: ceiling = LIMIT_L3;
      16'h0004: ceiling = LIMIT_L4;
      16'h0005: ceiling = LIMIT_L4;
      default: ceiling = NUM_LEVEL;
    endcase
  end

  // Only implemented numbers exist; gaps are skipped
  always_comb begin
    assigned = (num == NUM_LEVEL) || (num == NUM_MODE) ||
               (num >= NUM_MAX_FREQ && num <= NUM_RAMP_LAST) ||
               (num == NUM_UPPER) || (num == NUM_LOWER) || (num == NUM_CURRENT) ||
               (num >= NUM_IN_FIRST && num <= NUM_IN_LAST) ||
               (num >= NUM_SKIP_ONE && num <= NUM_SKIP_THREE) ||
               (num == NUM_SECOND_A) || (num == NUM_SECOND_B);
  end

  assign write_ok = assigned && num <= ceiling;
  assign run_in_prog = (level == LEVEL_RUN_PROG);
endmodule : level_decode

// >>> core/parameter_access_validator.sv
// Parameter store of a drive with access levels and write validation.
// Assumes an AXI4-Lite master on aclk; constant n sits at byte 4*n.
// Contract
// - Level sets write ceiling; all readable
// - Level five also accepts run in programming
// - Six clears faults, twelve/thirteen restore defaults
// - Unassigned numbers are skipped, never accessed
// - Illegal write: one-second error, data restored
// - Duplicate input functions flag an error
// - Curve points must keep their order
// - Mid frequency below both second-motor limits
// - Skip frequencies three, two, one ascending
// - Lower limit not above upper limit
// - Motor current at most 150 percent
// - Fine time unit refused above 600 s
// - Equal min and mid ignore mid voltage
// - Mode zero V/f default, one vector
// - Base frequency 0.2 to 400.0 Hz
// - After fault clear level shows previous
`timescale 1ns/1ps
module parameter_access_validator #(
  parameter int ERR_TICK_CYCLES = param_store_pkg::TICK_CYCLES,
  parameter int ERR_TICKS = param_store_pkg::TICKS_PER_SHOW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_request,
  output logic run_accept,
  output logic vector_mode,
  output logic err_display,
  output logic fault_history_clear,
  output logic three_wire_init,
  output logic irq
);
  import param_store_pkg::*;
  initial begin
    if (ERR_TICK_CYCLES < 1 || ERR_TICKS < 1) $error("timer counts must be positive");
  end

  localparam int NWORDS = 256;
  logic [15:0] store_r [NWORDS]; // Constant values by number
  logic [15:0] prev_level_r; // Level before a special value
  logic [11:0] aw_addr_r; // Held write address
  logic aw_have_r; // Write address taken
  logic [31:0] w_data_r; // Held write data
  logic [3:0] w_strb_r; // Held strobes
  logic w_have_r; // Write data taken
  irq_t irq_stat_r; // Sticky events
  irq_t irq_mask_r; // Enables
  logic [15:0] drive_rated_r; // Drive rated current, 0.1 A
  logic err_start; // One-cycle error pulse
  logic write_ok, assigned, run_in_prog;
  access_t acc; // Pending store write
  logic wr_fire; // Write both halves present
  logic wr_store; // Write hits a constant word
  logic wr_legal; // Candidate passes all checks
  logic [15:0] cand [NWORDS]; // Store as it would be after the write
  logic [15:0] level_now;

  // Execute once, in the cycle before the response rises
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  // Constant number from the word address; upper data bits ignored
  assign acc.num = aw_addr_r[9:2];
  assign acc.data = w_data_r[15:0];
  // Upper offsets are control registers, not constants
  assign wr_store = wr_fire && aw_addr_r[11:10] == 2'b00;
  // Level constant read straight from the store
  assign level_now = store_r[NUM_LEVEL];

  // Level decode of the held write address
  level_decode u_level (
    .level(level_now),
    .num(acc.num),
    .write_ok(write_ok),
    .assigned(assigned),
    .run_in_prog(run_in_prog)
  );

  // Candidate image for validation before commit
  always_comb begin
    for (int i = 0; i < NWORDS; i++) begin
      cand[i] = store_r[i];
    end
    cand[acc.num] = acc.data;
  end

  // Consistency checks over the candidate image
  always_comb begin
    logic dup;
    logic ramp_long;
    dup = 1'b0;
    ramp_long = 1'b0;
    for (int a = 32'(NUM_IN_FIRST); a <= 32'(NUM_IN_LAST); a++) begin
      for (int b = a + 1; b <= 32'(NUM_IN_LAST); b++) begin
        if (cand[a] == cand[b]) dup = 1'b1;
      end
    end
    for (int r = 32'(NUM_RAMP_FIRST); r <= 32'(NUM_RAMP_LAST); r++) begin
      if (cand[r] > RAMP_LIMIT) ramp_long = 1'b1;
    end
    wr_legal = !dup &&
      cand[NUM_MIN_FREQ] <= cand[NUM_MID_FREQ] &&
      cand[NUM_MID_FREQ] < cand[NUM_BASE_FREQ] &&
      cand[NUM_BASE_FREQ] <= cand[NUM_MAX_FREQ] &&
      cand[NUM_MID_FREQ] < cand[NUM_SECOND_A] &&
      cand[NUM_MID_FREQ] < cand[NUM_SECOND_B] &&
      cand[NUM_SKIP_THREE] <= cand[NUM_SKIP_TWO] &&
      cand[NUM_SKIP_TWO] <= cand[NUM_SKIP_ONE] &&
      cand[NUM_LOWER] <= cand[NUM_UPPER] &&
      {2'b00, cand[NUM_CURRENT]} * 18'h2 <= {2'b00, drive_rated_r} * 18'h3 &&
      !(acc.num == NUM_TIME_UNIT && acc.data == UNIT_FINE && ramp_long) &&
      cand[NUM_BASE_FREQ] >= BASE_MIN && cand[NUM_BASE_FREQ] <= BASE_MAX &&
      cand[NUM_MODE] <= MODE_VECTOR;
  end

  // Level writes skip the checks so a locked store can be reopened
  logic is_level_wr; // Write aimed at the level constant
  assign is_level_wr = wr_store && write_ok && acc.num == NUM_LEVEL;
  logic do_init;
  assign do_init = is_level_wr && (acc.data == LEVEL_INIT || acc.data == LEVEL_INIT_3W);
  logic do_clear;
  assign do_clear = is_level_wr && acc.data == LEVEL_CLR_FAULT;
  // Error only for in-level writes that break a relation
  assign err_start = wr_store && write_ok && !is_level_wr && !wr_legal;

  // Store update: defaults on reset or init, commit only legal writes
  always_ff @(posedge aclk) begin
    if (!aresetn || do_init) begin
      for (int i = 0; i < NWORDS; i++) begin
        store_r[i] <= 16'h0000;
      end
      store_r[NUM_LEVEL] <= DEF_LEVEL;
      store_r[NUM_MODE] <= 16'h0000;
      store_r[NUM_MAX_FREQ] <= DEF_MAX_FREQ;
      store_r[NUM_MAX_VOLT] <= DEF_MAX_VOLT;
      store_r[NUM_BASE_FREQ] <= DEF_BASE_FREQ;
      store_r[NUM_MID_FREQ] <= DEF_MID_FREQ;
      store_r[NUM_MID_VOLT] <= DEF_MID_VOLT;
      store_r[NUM_MIN_FREQ] <= DEF_MIN_FREQ;
      store_r[NUM_MIN_VOLT] <= DEF_MIN_VOLT;
      store_r[NUM_UPPER] <= DEF_UPPER;
      store_r[NUM_CURRENT] <= DEF_CURRENT;
      store_r[NUM_SECOND_A] <= DEF_SECOND_LIM;
      store_r[NUM_SECOND_B] <= DEF_SECOND_LIM;
      for (int r = 32'(NUM_RAMP_FIRST); r <= 32'(NUM_RAMP_LAST); r++) begin
        store_r[r] <= DEF_RAMP;
      end
      // Input functions start distinct so the duplicate check passes
      for (int k = 0; k < 7; k++) begin
        store_r[32'(NUM_IN_FIRST) + k] <= 16'(k);
      end
    end else if (do_clear) begin
      store_r[NUM_LEVEL] <= prev_level_r;
    end else if (is_level_wr) begin
      store_r[NUM_LEVEL] <= acc.data;
    end else if (wr_store && write_ok && wr_legal) begin
      store_r[acc.num] <= acc.data;
    end
  end

  // Previous ordinary level, kept for the fault-clear return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_level_r <= DEF_LEVEL;
    end else if (is_level_wr && !do_clear && !do_init) begin
      prev_level_r <= acc.data;
    end
  end

  // Error indication; a new error restarts it
  err_timer #(.TICK_LEN(ERR_TICK_CYCLES), .TICKS(ERR_TICKS)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(err_start),
    .showing(err_display)
  );

  // Action strobes towards the drive core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_history_clear <= 1'b0;
      three_wire_init <= 1'b0;
      run_accept <= 1'b0;
      vector_mode <= 1'b0;
    end else begin
      fault_history_clear <= do_clear || do_init;
      three_wire_init <= do_init && acc.data == LEVEL_INIT_3W;
      run_accept <= run_request && run_in_prog;
      vector_mode <= store_r[NUM_MODE] == MODE_VECTOR;
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Low while a half waits or a response stands
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;

  // Write response; unassigned numbers and unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_store) begin
        s_axi_bresp <= assigned ? RESP_OKAY : RESP_SLVERR;
      end else begin
        unique case (aw_addr_r)
          OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_DRIVE_RATED: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Mask and rated current; strobe byte 0 gates the small fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= '0;
      drive_rated_r <= 16'h0000;
    end else if (wr_fire && w_strb_r[0]) begin
      if (aw_addr_r == OFS_IRQ_MASK) irq_mask_r <= w_data_r[IRQ_BITS-1:0];
      if (aw_addr_r == OFS_DRIVE_RATED) drive_rated_r <= w_data_r[15:0];
    end
  end

  // Clear and event terms of the sticky status
  irq_t irq_clr; // Write-one-to-clear bits
  irq_t irq_set; // Events of this cycle
  assign irq_clr = (wr_fire && w_strb_r[0] && aw_addr_r == OFS_IRQ_STAT) ?
                   irq_t'(w_data_r[IRQ_BITS-1:0]) : irq_t'('0);
  assign irq_set.set_error = err_start;
  assign irq_set.fault_clr = do_clear || do_init;
  assign irq_set.init_done = do_init;

  // Sticky events: set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  // Interrupt level from registered status and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // One read at a time; no new address while data stands
  assign s_axi_arready = !s_axi_rvalid;

  // Read channel: every assigned constant is readable at any level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      if (s_axi_araddr[11:10] == 2'b00) begin
        if (rd_assigned(s_axi_araddr[9:2])) begin
          s_axi_rdata <= {16'h0000, rd_value(s_axi_araddr[9:2])};
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end else begin
        unique case (s_axi_araddr)
          OFS_STATUS: s_axi_rdata <= {29'h0, run_in_prog, vector_mode, err_display};
          OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_r};
          OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_r};
          OFS_DRIVE_RATED: s_axi_rdata <= {16'h0000, drive_rated_r};
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Read view; mid voltage reads zero while min equals mid
  function automatic logic [15:0] rd_value(input logic [7:0] n);
    if (n == NUM_MID_VOLT && store_r[NUM_MIN_FREQ] == store_r[NUM_MID_FREQ]) begin
      return 16'h0000;
    end
    return store_r[n];
  endfunction : rd_value

  // Same map as the decoder, for the read address
  function automatic logic rd_assigned(input logic [7:0] n);
    return (n == NUM_LEVEL) || (n == NUM_MODE) ||
           (n >= NUM_MAX_FREQ && n <= NUM_RAMP_LAST) ||
           (n == NUM_UPPER) || (n == NUM_LOWER) || (n == NUM_CURRENT) ||
           (n >= NUM_IN_FIRST && n <= NUM_IN_LAST) ||
           (n >= NUM_SKIP_ONE && n <= NUM_SKIP_THREE) ||
           (n == NUM_SECOND_A) || (n == NUM_SECOND_B);
  endfunction : rd_assigned
endmodule : parameter_access_validator

// >>> test/param_store_asserts.sv
// Checker for the bus handshakes and event pulses of the parameter store.
// Assumes it is bound to the top module, ports connected by name.
`timescale 1ns/1ps
module param_store_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_request,
  input wire logic run_accept,
  input wire logic fault_history_clear,
  input wire logic three_wire_init
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until the master takes them
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
  // Fixed answer latencies
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  // No new request taken while an answer waits
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // Run only follows a request one cycle back
  run_delay_a: assert property (run_accept |-> $past(run_request))
    else $error("run accepted without request");
  // Three-wire restore is also a fault clear, both single pulses
  init_pulse_a: assert property (three_wire_init |-> fault_history_clear)
    else $error("three-wire restore without clear");
  clear_pulse_a: assert property (fault_history_clear |=> !fault_history_clear)
    else $error("clear pulse too long");
  write_c: cover property (s_axi_bvalid && s_axi_bready);
  run_c: cover property (run_accept);
  init_c: cover property (three_wire_init);
endmodule : param_store_asserts

// >>> test/host_panel.sv
// Operator side model: holds the run switch level.
// Assumes want changes just after a rising edge.
`timescale 1ns/1ps
module host_panel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic want,
  output logic run_request
);
  // Switch is registered like a debounced key, low in reset
  always_ff @(posedge aclk) begin
    run_request <= aresetn && want;
  end
endmodule : host_panel

// >>> test/parameter_access_validator_test.sv
// Self-checking bench for the parameter store over AXI4-Lite.
// Assumes short error timer parameters: four-cycle tick, three ticks.
`timescale 1ns/1ps
module parameter_access_validator_test;
  import param_store_pkg::*;
  logic aclk = 0, aresetn = 0, want = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  // Ready for answers held high throughout
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, run_request, run_accept, vector_mode, err_display;
  logic fault_history_clear, three_wire_init, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0, n_compared = 0, cyc = 0, n_clr = 0, n_3w = 0;
  parameter_access_validator #(.ERR_TICK_CYCLES(4), .ERR_TICKS(3)) parameter_access_validator_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_request, .run_accept,
    .vector_mode, .err_display, .fault_history_clear, .three_wire_init, .irq);
  host_panel host_panel_i (.aclk, .aresetn, .want, .run_request);
  initial forever #25 aclk = ~aclk;
  // Pulse counts and hang limit, sampled mid-cycle to avoid edge races
  always @(negedge aclk) begin
    cyc++;
    if (fault_history_clear === 1'b1) n_clr++;
    if (three_wire_init === 1'b1) n_3w++;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [11:0] ad(input logic [7:0] n);
    return {2'b00, n, 2'b00};
  endfunction : ad
  // Address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, ha, hw;
    ha = 0;
    hw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      ha |= ta;
      hw |= tw;
    end while (!(ha && hw));
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (t !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rresp, er);
    // Data only means something on a good answer
    if (er == RESP_OKAY) chk(s_axi_rdata, {16'h0000, e});
    @(posedge aclk);
  endtask : rd
  // Illegal write: error shown, stored value kept
  task automatic ew(input logic [7:0] n, input logic [15:0] d, input logic [15:0] old);
    wr(ad(n), d, RESP_OKAY);
    @(negedge aclk);
    chk(err_display, 1);
    rd(ad(n), old, RESP_OKAY);
    repeat (14) @(posedge aclk);
  endtask : ew
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ad(NUM_LEVEL), DEF_LEVEL, RESP_OKAY);
    rd(ad(NUM_BASE_FREQ), 16'h01F4, RESP_OKAY);
    rd(ad(NUM_MODE), 16'h0000, RESP_OKAY);
    chk(vector_mode, 0);
    wr(ad(NUM_LOWER), 16'h0005, RESP_OKAY);
    rd(ad(NUM_LOWER), 16'h0005, RESP_OKAY);
    wr(ad(NUM_IN_FIRST), 16'h0001, RESP_OKAY);
    rd(ad(NUM_IN_FIRST), 16'h0000, RESP_OKAY);
    chk(err_display, 0);
    wr(ad(NUM_LEVEL), 16'h0000, RESP_OKAY);
    wr(ad(NUM_MAX_VOLT), 16'h0064, RESP_OKAY);
    rd(ad(NUM_MAX_VOLT), 16'h07D0, RESP_OKAY);
    wr(ad(NUM_LEVEL), 16'h0004, RESP_OKAY);
    rd(ad(8'h03), 16'h0000, RESP_SLVERR);
    rd(12'h800, 16'h0000, RESP_SLVERR);
    wr(OFS_IRQ_MASK, 16'h0007, RESP_OKAY);
    chk(irq, 0);
    ew(NUM_IN_FIRST, 16'h0001, 16'h0000);
    chk(irq, 1);
    wr(OFS_IRQ_STAT, 16'h0007, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk(irq, 0);
    rd(ad(NUM_MID_VOLT), 16'h0000, RESP_OKAY);
    ew(NUM_MIN_FREQ, 16'h000E, 16'h000D);
    ew(NUM_MID_FREQ, 16'h01F4, 16'h000D);
    ew(NUM_SECOND_A, 16'h000D, DEF_SECOND_LIM);
    ew(NUM_SKIP_THREE, 16'h000A, 16'h0000);
    ew(NUM_LOWER, 16'h03E9, 16'h0005);
    ew(NUM_CURRENT, 16'h0001, 16'h0000);
    wr(OFS_DRIVE_RATED, 16'h000A, RESP_OKAY);
    wr(ad(NUM_CURRENT), 16'h000F, RESP_OKAY);
    ew(NUM_CURRENT, 16'h0010, 16'h000F);
    wr(ad(NUM_RAMP_FIRST), 16'h1771, RESP_OKAY);
    ew(NUM_TIME_UNIT, UNIT_FINE, 16'h0000);
    ew(NUM_BASE_FREQ, 16'h0001, 16'h01F4);
    wr(ad(NUM_MAX_FREQ), 16'h0FA1, RESP_OKAY);
    ew(NUM_BASE_FREQ, 16'h0FA1, 16'h01F4);
    wr(ad(NUM_MID_FREQ), 16'h000E, RESP_OKAY);
    rd(ad(NUM_MID_VOLT), 16'h0078, RESP_OKAY);
    wr(ad(NUM_MODE), MODE_VECTOR, RESP_OKAY);
    @(negedge aclk);
    chk(vector_mode, 1);
    // Second error inside the window keeps the indication up
    wr(ad(NUM_LOWER), 16'h03E9, RESP_OKAY);
    repeat (8) @(posedge aclk);
    wr(ad(NUM_LOWER), 16'h03E9, RESP_OKAY);
    repeat (5) @(negedge aclk);
    chk(err_display, 1);
    @(posedge aclk);
    wr(ad(NUM_LEVEL), LEVEL_RUN_PROG, RESP_OKAY);
    want <= 1'b1;
    repeat (3) @(negedge aclk);
    chk(run_accept, 1);
    @(posedge aclk);
    want <= 1'b0;
    wr(ad(NUM_LEVEL), LEVEL_CLR_FAULT, RESP_OKAY);
    rd(ad(NUM_LEVEL), LEVEL_RUN_PROG, RESP_OKAY);
    chk(n_clr, 1);
    wr(ad(NUM_LEVEL), LEVEL_INIT_3W, RESP_OKAY);
    rd(ad(NUM_LEVEL), DEF_LEVEL, RESP_OKAY);
    rd(ad(NUM_CURRENT), DEF_CURRENT, RESP_OKAY);
    chk(n_3w, 1);
    chk(vector_mode, 0);
    wr(ad(NUM_LEVEL), LEVEL_INIT, RESP_OKAY);
    chk(n_clr, 3);
    chk(n_3w, 1);
    end_of_test();
  end
endmodule : parameter_access_validator_test
bind parameter_access_validator param_store_asserts param_store_asserts_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .run_request, .run_accept, .fault_history_clear, .three_wire_init);
